// >>> rtl/dccs_bank.v
/*
 * Configuration and status register bank of a two-channel DDR/DDR2
 * controller: ECC poison control, termination and strobe settings,
 * command clock and clock-enable disables, and the channel configuration
 * state machine for DIMM sparing.
 * Assumes byte-wide configuration writes and reads on the core clock; the
 * memory engine reports copy completion, rank symmetry and channel count.
 */
// Functional notes
// - Poison off recomputes ECC, on forwards it
// - Injection and logging ignore poison bit
// - Channel B read termination from 31:30
// - Channel A read termination from 29:28
// - Bit 8 picks strobe amplifier gain
// - Bit 7 enables differential strobes
// - Clock disable bits tri-state pairs, reset FF
// - Clock-enable disable bits, reset all enabled
// - Transition enable write-one-set, hardware clears
// - Transition enable leaves idle, starts migration
// - Sparing enable blocks symmetric decode
// - Copy source field selects CS pair
// - Copy starts only with transition enable
// - Symmetric mode reported in bit 4
// - Bits 3:0 report state machine state
`timescale 1ns/1ps
`include "dccs_map.vh"

module dccs_bank (
    clk,
    rst,
    cfg_wr,
    cfg_rd,
    cfg_addr,
    cfg_wdata,
    cfg_rdata,
    bad_ecc_in,
    copy_done,
    dual_channel,
    equal_ranks,
    ecc_recompute,
    strobe_half_gain,
    differential_strobe_enable,
    odt_strength_a,
    odt_strength_b,
    dimm_command_clock_oe,
    cke_enable,
    symmetric_mode,
    copy_active,
    copy_source_pair,
    spare_state
);
    parameter CLK_PAIRS = 8; // Command clock pairs
    parameter CKE_PINS = 8; // Clock-enable pins

    input wire clk;
    input wire rst;
    input wire cfg_wr; // Byte write strobe
    input wire cfg_rd; // Byte read strobe
    input wire [7:0] cfg_addr; // Byte address
    input wire [7:0] cfg_wdata; // Write byte
    output reg [7:0] cfg_rdata; // Read byte, held
    input wire bad_ecc_in; // Inbound write carries bad ECC
    input wire copy_done; // Migration engine finished
    input wire dual_channel; // Both channels populated
    input wire equal_ranks; // Four equal ranks present
    output reg ecc_recompute;
    output reg strobe_half_gain;
    output reg differential_strobe_enable;
    output reg [1:0] odt_strength_a;
    output reg [1:0] odt_strength_b;
    output reg [CLK_PAIRS-1:0] dimm_command_clock_oe;
    output reg [CKE_PINS-1:0] cke_enable;
    output reg symmetric_mode;
    output reg copy_active;
    output reg [1:0] copy_source_pair;
    output reg [3:0] spare_state;

    // ======================================================
    // Register storage
    // ======================================================
    reg poison_en; // ECC diagnostic bit 18
    reg [1:0] odt_b; // Channel B termination code
    reg [1:0] odt_a; // Channel A termination code
    reg half_gain; // Strobe gain select
    reg diff_strobe; // Differential strobe enable
    reg [CLK_PAIRS-1:0] ck_dis; // Command clock disables
    reg [CKE_PINS-1:0] cke_dis; // Clock-enable disables
    reg trans_en; // Transition enable
    reg spare_en; // Sparing enable
    reg [1:0] copy_src; // Failing pair
    reg [3:0] state; // Channel config state
    reg [3:0] next_state;
    reg trans_done; // State change seen this cycle
    wire [1:0] odt_a_dec;
    wire [1:0] odt_b_dec;
    wire symm_now;

    // ======================================================
    // Configuration writes
    // ======================================================
    // Byte lanes decoded one address at a time
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            poison_en <= `DCCS_RST_ECC_DIAG;
            {odt_b, odt_a, half_gain, diff_strobe} <= `DCCS_RST_SEC_CTRL;
            ck_dis <= `DCCS_RST_CK_DIS;
            cke_dis <= `DCCS_RST_CKE_DIS;
            {trans_en, spare_en, copy_src} <= `DCCS_RST_CFG_CSR;
        end else begin
            // hardware clear, a set in the same cycle wins
            if (trans_done) begin
                trans_en <= 1'b0;
            end
            if (cfg_wr) begin
                if (cfg_addr == `DCCS_OFF_ECC_DIAG + 8'h2) begin
                    poison_en <= cfg_wdata[`DCCS_POISON_BIT - 16];
                end else if (cfg_addr == `DCCS_OFF_SEC_CTRL) begin
                    diff_strobe <= cfg_wdata[`DCCS_DIFF_STROBE_BIT];
                end else if (cfg_addr == `DCCS_OFF_SEC_CTRL + 8'h1) begin
                    half_gain <= cfg_wdata[`DCCS_HALF_GAIN_BIT - 8];
                end else if (cfg_addr == `DCCS_OFF_SEC_CTRL + 8'h3) begin
                    odt_b <= cfg_wdata[`DCCS_ODT_B_HI-24:`DCCS_ODT_B_LO-24];
                    odt_a <= cfg_wdata[`DCCS_ODT_A_HI-24:`DCCS_ODT_A_LO-24];
                end else if (cfg_addr == `DCCS_OFF_CK_DIS) begin
                    ck_dis <= cfg_wdata[CLK_PAIRS-1:0];
                end else if (cfg_addr == `DCCS_OFF_CKE_DIS) begin
                    cke_dis <= cfg_wdata[CKE_PINS-1:0];
                end else if (cfg_addr == `DCCS_OFF_CFG_CSR) begin
                    copy_src[0] <= cfg_wdata[`DCCS_SRC_LO];
                end else if (cfg_addr == `DCCS_OFF_CFG_CSR + 8'h1) begin
                    copy_src[1] <= cfg_wdata[`DCCS_SRC_HI - 8];
                    spare_en <= cfg_wdata[`DCCS_SPARE_EN_BIT - 8];
                    if (cfg_wdata[`DCCS_TRANS_EN_BIT - 8]) begin
                        trans_en <= 1'b1;
                    end
                end
            end
        end
    end

    // ======================================================
    // Channel configuration state machine
    // ======================================================
    // symmetric only outside sparing
    assign symm_now = equal_ranks & ~spare_en;

    // Next state; idle, normal and complete states move only while transition enable is set, copy states move on copy_done
    always @* begin
        next_state = state;
        trans_done = 1'b0;
        case (state)
            `DCCS_ST_IDLE: begin
                if (trans_en) begin
                    next_state = dual_channel ? `DCCS_ST_D_NORM
                                              : `DCCS_ST_A_NORM;
                end
            end
            `DCCS_ST_A_NORM, `DCCS_ST_D_NORM, `DCCS_ST_A_DONE,
            `DCCS_ST_B_DONE, `DCCS_ST_D_DONE: begin
                if (trans_en && spare_en) begin
                    if (state == `DCCS_ST_D_NORM ||
                        state == `DCCS_ST_D_DONE) begin
                        next_state = `DCCS_ST_D_COPY;
                    end else if (state == `DCCS_ST_B_DONE) begin
                        next_state = `DCCS_ST_B_COPY;
                    end else begin
                        next_state = `DCCS_ST_A_COPY;
                    end
                end
            end
            `DCCS_ST_A_COPY: begin
                if (copy_done) begin
                    next_state = `DCCS_ST_A_DONE;
                end
            end
            `DCCS_ST_B_COPY: begin
                if (copy_done) begin
                    next_state = `DCCS_ST_B_DONE;
                end
            end
            `DCCS_ST_D_COPY: begin
                if (copy_done) begin
                    next_state = `DCCS_ST_D_DONE;
                end
            end
            default: begin
                // Reserved codes fall back to idle
                next_state = `DCCS_ST_IDLE;
            end
        endcase
        // clear once a state change happened
        if (next_state != state && trans_en) begin
            trans_done = 1'b1;
        end
    end

    // State register
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= `DCCS_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ======================================================
    // Termination decode
    // ======================================================
    // channel B termination
    dccs_odt_decode u_odt_b (
        .field(odt_b),
        .strength(odt_b_dec)
    );
    // Each channel has its own decoder instance, so the two codes are independent

    dccs_odt_decode u_odt_a (
        .field(odt_a),
        .strength(odt_a_dec)
    );

    // ======================================================
    // Registered outputs
    // ======================================================
    // Every pin-facing control comes straight from a flop
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ecc_recompute <= 1'b0;
            strobe_half_gain <= 1'b0;
            differential_strobe_enable <= 1'b0;
            odt_strength_a <= `DCCS_ODT_OFF;
            odt_strength_b <= `DCCS_ODT_OFF;
            dimm_command_clock_oe <= {CLK_PAIRS{1'b0}};
            cke_enable <= {CKE_PINS{1'b1}};
            symmetric_mode <= 1'b0;
            copy_active <= 1'b0;
            copy_source_pair <= 2'h0;
            spare_state <= `DCCS_ST_IDLE;
        end else begin
            // error reporting path not touched here
            ecc_recompute <= bad_ecc_in & ~poison_en;
            strobe_half_gain <= half_gain;
            differential_strobe_enable <= diff_strobe;
            odt_strength_a <= odt_a_dec;
            odt_strength_b <= odt_b_dec;
            dimm_command_clock_oe <= ~ck_dis;
            cke_enable <= ~cke_dis;
            symmetric_mode <= symm_now;
            copy_active <= (next_state == `DCCS_ST_A_COPY) ||
                           (next_state == `DCCS_ST_B_COPY) ||
                           (next_state == `DCCS_ST_D_COPY);
            // source pair to the migration engine
            copy_source_pair <= copy_src;
            spare_state <= next_state;
        end
    end

    // ======================================================
    // Configuration reads
    // ======================================================
    // Read data held until the next read; unmapped bytes read zero
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_rdata <= 8'h00;
        end else if (cfg_rd) begin
            if (cfg_addr == `DCCS_OFF_ECC_DIAG + 8'h2) begin
                cfg_rdata <= {5'h00, poison_en, 2'h0};
            end else if (cfg_addr == `DCCS_OFF_SEC_CTRL) begin
                cfg_rdata <= {diff_strobe, 7'h00};
            end else if (cfg_addr == `DCCS_OFF_SEC_CTRL + 8'h1) begin
                cfg_rdata <= {7'h00, half_gain};
            end else if (cfg_addr == `DCCS_OFF_SEC_CTRL + 8'h3) begin
                cfg_rdata <= {odt_b, odt_a, 4'h0};
            end else if (cfg_addr == `DCCS_OFF_CK_DIS) begin
                cfg_rdata <= ck_dis;
            end else if (cfg_addr == `DCCS_OFF_CKE_DIS) begin
                cfg_rdata <= cke_dis;
            end else if (cfg_addr == `DCCS_OFF_CFG_CSR) begin
                cfg_rdata <= {copy_src[0], 2'h0, symm_now, state};
            end else if (cfg_addr == `DCCS_OFF_CFG_CSR + 8'h1) begin
                cfg_rdata <= {trans_en, 5'h00, spare_en, copy_src[1]};
            end else begin
                cfg_rdata <= 8'h00;
            end
        end
    end

endmodule // dccs_bank

// >>> rtl/dccs_map.vh
/*
 * Register map constants for the DDR channel configuration and sparing
 * register bank: byte offsets, field positions, reset values.
 * Assumes it is included by bare name from the rtl/ design files.
 */
`ifndef DCCS_MAP_VH
`define DCCS_MAP_VH

// ==========================================================
// Byte offsets in configuration space
// ==========================================================
`define DCCS_OFF_ECC_DIAG 8'h84
`define DCCS_OFF_SEC_CTRL 8'h88
`define DCCS_OFF_CK_DIS 8'h8C
`define DCCS_OFF_CKE_DIS 8'h8D
`define DCCS_OFF_CFG_CSR 8'h9A

// ==========================================================
// Field positions
// ==========================================================
`define DCCS_POISON_BIT 18
`define DCCS_ODT_B_HI 31
`define DCCS_ODT_B_LO 30
`define DCCS_ODT_A_HI 29
`define DCCS_ODT_A_LO 28
`define DCCS_HALF_GAIN_BIT 8
`define DCCS_DIFF_STROBE_BIT 7
`define DCCS_TRANS_EN_BIT 15
`define DCCS_SPARE_EN_BIT 9
`define DCCS_SRC_HI 8
`define DCCS_SRC_LO 7
`define DCCS_SYMM_BIT 4

// ==========================================================
// Reset values
// ==========================================================
`define DCCS_RST_ECC_DIAG 1'h0
`define DCCS_RST_SEC_CTRL 6'h00
`define DCCS_RST_CK_DIS 8'hFF
`define DCCS_RST_CKE_DIS 8'h00
`define DCCS_RST_CFG_CSR 4'h0

// ==========================================================
// State codes of the channel configuration state machine
// ==========================================================
`define DCCS_ST_IDLE 4'h0
`define DCCS_ST_A_NORM 4'h4
`define DCCS_ST_A_COPY 4'h5
`define DCCS_ST_A_DONE 4'h7
`define DCCS_ST_B_COPY 4'h9
`define DCCS_ST_B_DONE 4'hB
`define DCCS_ST_D_NORM 4'hC
`define DCCS_ST_D_COPY 4'hD
`define DCCS_ST_D_DONE 4'hF

// Termination strength codes driven to the pad control
`define DCCS_ODT_OFF 2'h0
`define DCCS_ODT_MID 2'h1
`define DCCS_ODT_STRONG 2'h2

`endif

// >>> rtl/dccs_odt_decode.v
/*
 * Decoder from a two-bit termination field to a pad strength code.
 * Assumes a plain combinational context; the caller registers the result.
 */
`timescale 1ns/1ps
`include "dccs_map.vh"

module dccs_odt_decode (
    input wire [1:0] field,
    output reg [1:0] strength
);

// ==========================================================
// Encoding map
// ==========================================================
// Codes 01 and 10 share one strength on purpose
always @* begin
    case (field)
        2'h0: begin
            strength = `DCCS_ODT_OFF;
        end
        2'h3: begin
            strength = `DCCS_ODT_STRONG;
        end
        default: begin
            strength = `DCCS_ODT_MID;
        end
    endcase
end

endmodule // dccs_odt_decode

// >>> dv/dccs_bank_properties.sv
/* Checker for the channel configuration bank.
   Assumes it is bound to dccs_bank and sees its ports only. */
`timescale 1ns/1ps
module dccs_bank_chk (
    input wire clk,
    input wire rst,
    input wire cfg_wr,
    input wire bad_ecc_in,
    input wire copy_done,
    input wire equal_ranks,
    input wire ecc_recompute,
    input wire symmetric_mode,
    input wire copy_active,
    input wire [1:0] odt_strength_a,
    input wire [1:0] odt_strength_b,
    input wire [3:0] spare_state
);
    // ==============================================
    // Assertions, one clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_ecc_no_recompute: assert property (
        !bad_ecc_in |=> !ecc_recompute)
        else $error("recompute without bad ecc");
    chk_symm_needs_ranks: assert property (
        symmetric_mode |-> $past(equal_ranks))
        else $error("symmetric without equal ranks");
    chk_copy_no_symm: assert property (
        copy_active |-> !symmetric_mode)
        else $error("copy while symmetric");
    chk_odt_code_legal: assert property (
        odt_strength_a != 2'h3 && odt_strength_b != 2'h3)
        else $error("bad termination code");
    chk_copy_flag_state: assert property (
        copy_active == (spare_state inside {4'h5, 4'h9, 4'hD}))
        else $error("copy flag and state disagree");
    chk_state_code_legal: assert property (
        spare_state inside {4'h0, 4'h4, 4'h5, 4'h7, 4'h9, 4'hB,
                            4'hC, 4'hD, 4'hF})
        else $error("illegal state code");
    chk_copy_done_step: assert property (
        copy_active && copy_done |=>
        spare_state == $past(spare_state) + 4'h2)
        else $error("copy did not complete");
    // Complete states hold while software is silent; a write in the
    // previous cycle may still be moving the machine
    chk_done_state_holds: assert property (
        spare_state inside {4'h7, 4'hB, 4'hF} && !cfg_wr &&
        !$past(cfg_wr) |=> $stable(spare_state))
        else $error("complete state left");
    chk_idle_state_holds: assert property (
        spare_state == 4'h0 && !cfg_wr && !$past(cfg_wr) |=>
        spare_state == 4'h0)
        else $error("idle left without write");
    cov_copy: cover property (copy_active && copy_done);
    cov_symm: cover property (symmetric_mode);
    cov_dual_done: cover property (spare_state == 4'hF);
endmodule // dccs_bank_chk

bind dccs_bank dccs_bank_chk u_chk (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
    .bad_ecc_in(bad_ecc_in), .copy_done(copy_done),
    .equal_ranks(equal_ranks), .ecc_recompute(ecc_recompute),
    .symmetric_mode(symmetric_mode), .copy_active(copy_active),
    .odt_strength_a(odt_strength_a), .odt_strength_b(odt_strength_b),
    .spare_state(spare_state));

// >>> dv/dccs_dimm_model.sv
/* Memory side model: finishes a sparing copy after a delay.
   Assumes copy_active from the bank marks a copy in flight. */
`timescale 1ns/1ps
module dccs_dimm_model (
    input wire clk,
    input wire rst,
    input wire copy_active,
    input wire slow,
    output reg copy_done
);
    // ==============================================
    // Copy timing
    localparam [7:0] FAST = 8'h04; // Prompt copy
    localparam [7:0] SLOW = 8'h20; // Long copy
    reg [7:0] cnt; // Cycles into copy
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 8'h00;
            copy_done <= 1'b0;
        end else if (!copy_active) begin
            cnt <= 8'h00;
            copy_done <= 1'b0;
        end else begin
            cnt <= cnt + 8'h01;
            copy_done <= (cnt == (slow ? SLOW : FAST));
        end
    end
endmodule // dccs_dimm_model

// >>> dv/test_ddr_channel_config_sparing.sv
/* Self-checking bench for the channel configuration bank.
   Assumes dccs_bank, its checker and the memory side model. */
`timescale 1ns/1ps
module test_ddr_channel_config_sparing;
    reg clk = 0;
    reg rst = 1;
    reg cfg_wr = 0;
    reg cfg_rd = 0;
    reg [7:0] cfg_addr = 8'h00;
    reg [7:0] cfg_wdata = 8'h00;
    reg bad_ecc_in = 0;
    reg dual_channel = 0;
    reg equal_ranks = 0;
    reg slow = 0;
    wire copy_done;
    wire [7:0] cfg_rdata;
    wire ecc_recompute, strobe_half_gain, differential_strobe_enable;
    wire symmetric_mode, copy_active;
    wire [1:0] odt_strength_a, odt_strength_b, copy_source_pair;
    wire [7:0] dimm_command_clock_oe, cke_enable;
    wire [3:0] spare_state;
    integer error_cnt = 0;
    integer comparisons = 0;
    integer cyc = 0;
    integer i;
    reg [31:0] lf = 32'h17AE; // Random source
    reg [7:0] v;
    dccs_bank u_dccs_bank (.clk(clk), .rst(rst), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .bad_ecc_in(bad_ecc_in),
        .copy_done(copy_done), .dual_channel(dual_channel),
        .equal_ranks(equal_ranks), .ecc_recompute(ecc_recompute),
        .strobe_half_gain(strobe_half_gain),
        .differential_strobe_enable(differential_strobe_enable),
        .odt_strength_a(odt_strength_a), .odt_strength_b(odt_strength_b),
        .dimm_command_clock_oe(dimm_command_clock_oe),
        .cke_enable(cke_enable), .symmetric_mode(symmetric_mode),
        .copy_active(copy_active), .copy_source_pair(copy_source_pair),
        .spare_state(spare_state));
    dccs_dimm_model u_dccs_dimm_model (.clk(clk), .rst(rst),
        .copy_active(copy_active), .slow(slow), .copy_done(copy_done));
    // ==============================================
    // Clock, timeout, helpers
    always #20 clk = ~clk;
    // Hang guard, the run needs about 270 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt = error_cnt + 1;
            end_sim;
        end
    end
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Pad strength expected for a termination code
    function [1:0] ost(input [1:0] c);
        ost = (c == 2'h0) ? 2'h0 : (c == 2'h3) ? 2'h2 : 2'h1;
    endfunction
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task chk(input string n, input [7:0] seen, input [7:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("wrong value %s exp %h seen %h", n, exp, seen);
        end
    endtask
    // One-cycle byte write strobe
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk);
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask
    // Read data is registered, so wait one more edge
    task rd(input [7:0] a);
        @(posedge clk);
        cfg_addr <= a;
        cfg_rd <= 1'b1;
        @(posedge clk);
        cfg_rd <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task do_reset;
        @(posedge clk);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
    endtask
    // Bring-up, enable sparing, copy, complete
    task run_fsm(input dual, input [3:0] base, input [1:0] src);
        dual_channel <= dual;
        equal_ranks <= 1'b1;
        slow <= dual;
        tick(3);
        chk("symm", symmetric_mode, 1'b1);
        wr(8'h9B, 8'h80);
        tick(3);
        chk("state", spare_state, base);
        rd(8'h9B);
        chk("trans", cfg_rdata, 8'h00);
        wr(8'h9A, {src[0], 7'h7F});
        wr(8'h9B, {1'b0, 5'h1F, 1'b1, src[1]});
        tick(3);
        chk("src", copy_source_pair, src);
        chk("symm", symmetric_mode, 1'b0);
        chk("state", spare_state, base);
        rd(8'h9B);
        chk("9B", cfg_rdata, {7'h01, src[1]});
        wr(8'h9B, {7'h41, src[1]});
        tick(3);
        chk("copy", spare_state, base + 4'h1);
        chk("act", copy_active, 1'b1);
        for (i = 0; i < 200 && spare_state != base + 4'h3; i = i + 1)
            tick(1);
        tick(4);
        chk("done", spare_state, base + 4'h3);
        chk("act", copy_active, 1'b0);
        rd(8'h9A);
        chk("9A", cfg_rdata, {src[0], 3'h0, base + 4'h3});
    endtask
    task end_sim;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==============================================
    // Main sequence
    initial begin
        tick(2);
        rst <= 1'b0;
        tick(1);
        #1;
        chk("oe", dimm_command_clock_oe, 8'h00);
        chk("cke", cke_enable, 8'hFF);
        rd(8'h8C);
        chk("8C", cfg_rdata, 8'hFF);
        rd(8'h9A);
        chk("9A", cfg_rdata, 8'h00);
        // Calibration pairs kept driven, bits 1 and 4 clear
        for (i = 0; i < 8; i = i + 1) begin
            lf = lfsr(lf);
            v = lf[7:0] & 8'hED;
            wr(8'h8C, v);
            wr(8'h8D, lf[15:8]);
            tick(2);
            chk("oe", dimm_command_clock_oe, ~v);
            chk("cke", cke_enable, ~lf[15:8]);
            rd(8'h8D);
            chk("8D", cfg_rdata, lf[15:8]);
        end
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'h8B, {i[1:0], 2'h3 - i[1:0], 4'hF});
            tick(2);
            chk("odtb", odt_strength_b, ost(i[1:0]));
            chk("odta", odt_strength_a, ost(2'h3 - i[1:0]));
            rd(8'h8B);
            chk("8B", cfg_rdata, {i[1:0], 2'h3 - i[1:0], 4'h0});
            wr(8'h9A, {i[0], 7'h00});
            wr(8'h9B, {7'h00, i[1]});
            tick(2);
            chk("src", copy_source_pair, i[1:0]);
        end
        bad_ecc_in <= 1'b1;
        tick(2);
        chk("ecc", ecc_recompute, 1'b1);
        wr(8'h86, 8'hFF);
        tick(2);
        chk("ecc", ecc_recompute, 1'b0);
        rd(8'h86);
        chk("86", cfg_rdata, 8'h04);
        bad_ecc_in <= 1'b0;
        wr(8'h88, 8'hFF);
        wr(8'h89, 8'hFF);
        wr(8'h90, 8'hFF);
        tick(2);
        chk("diff", differential_strobe_enable, 1'b1);
        chk("gain", strobe_half_gain, 1'b1);
        rd(8'h88);
        chk("88", cfg_rdata, 8'h80);
        rd(8'h89);
        chk("89", cfg_rdata, 8'h01);
        rd(8'h90);
        chk("90", cfg_rdata, 8'h00);
        do_reset;
        run_fsm(1'b0, 4'h4, 2'h1);
        do_reset;
        run_fsm(1'b1, 4'hC, 2'h2);
        end_sim;
    end
endmodule // test_ddr_channel_config_sparing
